// *** logic/fdi_consts.svh ***
`ifndef FDI_CONSTS_SVH
`define FDI_CONSTS_SVH

// fixed 7-bit bus address of the device, 011 0011
`define FDI_SLAVE_ADDR 7'h33
// high-speed master code pattern, upper five bits of 00001XXX
`define FDI_HS_CODE 5'h01
// upper five bits of a valid register address byte
`define FDI_PTR_UPPER 5'h00
// number of control registers, selected by three address bits
`define FDI_REG_COUNT 8
// default value of every control register
`define FDI_REG_RESET 8'h00
// value returned for an unmapped register address
`define FDI_READ_ZERO 8'h00
// bit counter: eight data bits received, acknowledge slot, first bit
`define FDI_BIT_ACK 4'h8
`define FDI_BIT_END 4'h9
`define FDI_BIT_FIRST 4'h0
// idle level of both bus lines, pulled up
`define FDI_BUS_IDLE 2'h3

`endif

// *** logic/fdi_pkg.sv ***
`default_nettype none

package fdi_pkg;

  // byte engine states, one-hot
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_ADDR = 6'b000010,
    S_REGA = 6'b000100,
    S_DATA = 6'b001000,
    S_READ = 6'b010000,
    S_SKIP = 6'b100000
  } fdi_state_e;

endpackage : fdi_pkg

`default_nettype wire

// *** logic/fdi_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// two-flop synchroniser for pin levels
module fdi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  // first stage, read only by the second stage
  logic [W-1:0] metaQ;

  // plain double register; reset takes constants only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      metaQ <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      metaQ <= asyncIn;
      syncOut <= metaQ;
    end
  end

endmodule : fdi_sync

`default_nettype wire

// *** logic/fdi_flash_i2c_slave.sv ***
// Overview of operation
// - slave only; standard, fast, high-speed rates
// - seven-bit addressing only; ignore others, no ack
// - answer only address 011 0011
// - master starts; device detects start condition
// - stop frees bus; await start and address
// - data stable while clock high
// - acknowledge matched address during ninth clock
// - nine-bit units; receiver acknowledges each byte
// - open-drain lines, only pull low
// - unmapped register reads return zero
// - master code not acknowledged; enter high-speed
// - repeated start then normal protocol, faster
// - stop leaves high-speed operation
// - write: address, register byte, data byte
// - register updates at acknowledge falling edge
// - register byte: low three bits select
// - hardware disable resets interface, registers, shutdown
`timescale 1ns/100ps
`default_nettype none
`include "fdi_consts.svh"

module fdi_flash_i2c_slave
  import fdi_pkg::*;
#(
  // one bit per register, set where the register exists
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // hardware disable pin, active low
  input wire logic hwDisableLow,
  // serial clock line, open drain
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe_n,
  // serial data line, open drain
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  // device status and register contents
  output logic shutdown,
  output logic hsMode,
  output logic [8*`FDI_REG_COUNT-1:0] regBank
);

  // synchronised pin levels
  logic sclS; // clock line after two flops
  logic sdaS; // data line after two flops
  logic hwOkS; // disable pin high after two flops

  // previous synchronised levels, for edge detection
  logic sclP;
  logic sdaP;

  // byte engine state
  fdi_state_e stateQ, stateD;
  logic [3:0] bitCntQ, bitCntD; // bits seen in the current unit
  logic [7:0] shiftQ, shiftD; // receive or transmit shifter
  logic driveQ, driveD; // pull data line low
  logic rwQ, rwD; // direction bit of the address byte
  logic [7:0] ptrQ, ptrD; // register address byte
  logic [7:0] dataQ, dataD; // data byte awaiting commit
  logic hsQ, hsD; // high-speed rate entered
  logic nackQ, nackD; // master answered not-acknowledge
  logic shutdownQ; // registered shutdown indication

  // register storage
  logic [7:0] regQ [`FDI_REG_COUNT];

  // decode wires
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic addrMatch;
  logic hsCode;
  logic ptrOk;
  logic [7:0] readData;
  logic wrEn;
  logic txPhase;
  logic busyState;
  logic hwHold;

  // pins cross into the clock domain through two flops
  fdi_sync #(
    .W(3),
    .RESET_VAL({`FDI_BUS_IDLE, 1'b0})
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .asyncIn({sclIn, sdaIn, hwDisableLow}),
    .syncOut({sclS, sdaS, hwOkS})
  );

  // previous levels start at the idle bus level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {sclP, sdaP} <= `FDI_BUS_IDLE;
    end else begin
      {sclP, sdaP} <= {sclS, sdaS};
    end
  end

  // edges on the clock line
  assign sclRise = sclS & ~sclP;
  assign sclFall = ~sclS & sclP;

  // start detect
  // data falls while clock stays high; a repeated start looks the same
  assign startDet = sclS & sclP & sdaP & ~sdaS;

  // stop detect
  // data rises while clock stays high
  assign stopDet = sclS & sclP & ~sdaP & sdaS;

  // address compare
  // only the full seven-bit value answers; general call and the
  // ten-bit prefix never equal it, so they fall out here too
  assign addrMatch = (shiftQ[7:1] == `FDI_SLAVE_ADDR);

  assign hsCode = (shiftQ[7:3] == `FDI_HS_CODE);

  // pointer check
  // upper bits must be zero, low three bits pick the register
  assign ptrOk = (ptrQ[7:3] == `FDI_PTR_UPPER);

  assign readData = (ptrOk && IMPL_MASK[ptrQ[2:0]]) ? regQ[ptrQ[2:0]] : `FDI_READ_ZERO;

  // commit strobe
  // the falling clock edge that closes the acknowledge slot of a data byte
  assign wrEn = sclFall & (bitCntQ == `FDI_BIT_END) & (stateQ == S_DATA) & ~startDet & ~stopDet;

  // the read state, the only transmit state, shifts out instead of in
  assign txPhase = (stateQ == S_READ);
  // states in which the engine follows clock pulses
  assign busyState = (stateQ != S_IDLE) && (stateQ != S_SKIP);
  // disable pin low holds everything at defaults
  assign hwHold = ~hwOkS;

  // next-state logic of the byte engine
  always_comb begin
    stateD = stateQ;
    bitCntD = bitCntQ;
    shiftD = shiftQ;
    driveD = driveQ;
    rwD = rwQ;
    ptrD = ptrQ;
    dataD = dataQ;
    hsD = hsQ;
    nackD = nackQ;
    if (stopDet) begin
      // stop ends high-speed
      // bus free again; only a new start wakes the engine
      stateD = S_IDLE;
      bitCntD = `FDI_BIT_FIRST;
      driveD = 1'b0;
      hsD = 1'b0;
    end else if (startDet) begin
      // repeated start resumes
      // high-speed flag survives a repeated start
      stateD = S_ADDR;
      bitCntD = `FDI_BIT_FIRST;
      driveD = 1'b0;
      nackD = 1'b0;
    end else if (busyState && sclRise) begin
      // sample on rise
      // data is taken once per high phase, after it has settled
      if (bitCntQ < `FDI_BIT_ACK) begin
        bitCntD = bitCntQ + 4'h1;
        if (!txPhase) begin
          shiftD = {shiftQ[6:0], sdaS};
        end
      end else if (bitCntQ == `FDI_BIT_END && txPhase) begin
        // master answer to our byte
        nackD = sdaS;
      end
    end else if (busyState && sclFall) begin
      if (txPhase && bitCntQ != `FDI_BIT_FIRST && bitCntQ < `FDI_BIT_ACK) begin
        // change on low
        // next transmit bit goes out only after the clock fell
        shiftD = {shiftQ[6:0], 1'b0};
        driveD = ~shiftQ[6];
      end else if (bitCntQ == `FDI_BIT_ACK) begin
        // acknowledge slot
        // eight bits in; decide the ninth clock
        bitCntD = `FDI_BIT_END;
        unique case (stateQ)
          S_ADDR: begin
            if (addrMatch) begin
              driveD = 1'b1;
              rwD = shiftQ[0];
            end else if (hsCode) begin
              hsD = 1'b1;
              stateD = S_SKIP;
            end else begin
              stateD = S_SKIP;
            end
          end
          S_REGA: begin
            driveD = 1'b1;
            ptrD = shiftQ;
          end
          S_DATA: begin
            driveD = 1'b1;
            dataD = shiftQ;
          end
          S_READ: begin
            // release so the master can answer
            driveD = 1'b0;
          end
          S_IDLE: begin
          end
          S_SKIP: begin
          end
        endcase
      end else if (bitCntQ == `FDI_BIT_END) begin
        // end of the acknowledge slot
        bitCntD = `FDI_BIT_FIRST;
        driveD = 1'b0;
        unique case (stateQ)
          S_ADDR: begin
            if (rwQ) begin
              // read answer
              // pointer kept from the earlier write phase
              stateD = S_READ;
              shiftD = readData;
              driveD = ~readData[7];
            end else begin
              stateD = S_REGA;
            end
          end
          S_REGA: begin
            stateD = S_DATA;
          end
          S_DATA: begin
            // further bytes rewrite the same register
            stateD = S_DATA;
          end
          S_READ: begin
            if (nackQ) begin
              stateD = S_SKIP;
            end else begin
              shiftD = readData;
              driveD = ~readData[7];
            end
          end
          S_IDLE: begin
          end
          S_SKIP: begin
          end
        endcase
      end
    end
  end

  // engine registers
  // the disable pin clears the interface like a reset, but through
  // the synchroniser, so release can never come mid-cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= S_IDLE;
      bitCntQ <= `FDI_BIT_FIRST;
      shiftQ <= `FDI_REG_RESET;
      driveQ <= 1'b0;
      rwQ <= 1'b0;
      ptrQ <= `FDI_REG_RESET;
      dataQ <= `FDI_REG_RESET;
      hsQ <= 1'b0;
      nackQ <= 1'b0;
    end else if (hwHold) begin
      stateQ <= S_IDLE;
      bitCntQ <= `FDI_BIT_FIRST;
      shiftQ <= `FDI_REG_RESET;
      driveQ <= 1'b0;
      rwQ <= 1'b0;
      ptrQ <= `FDI_REG_RESET;
      dataQ <= `FDI_REG_RESET;
      hsQ <= 1'b0;
      nackQ <= 1'b0;
    end else begin
      stateQ <= stateD;
      bitCntQ <= bitCntD;
      shiftQ <= shiftD;
      driveQ <= driveD;
      rwQ <= rwD;
      ptrQ <= ptrD;
      dataQ <= dataD;
      hsQ <= hsD;
      nackQ <= nackD;
    end
  end

  // shutdown follows the disable pin; held through reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shutdownQ <= 1'b1;
    end else begin
      shutdownQ <= hwHold;
    end
  end

  // one register per entry
  genvar gi;
  generate
    for (gi = 0; gi < `FDI_REG_COUNT; gi++) begin : g_reg
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          regQ[gi] <= `FDI_REG_RESET;
        end else if (hwHold) begin
          regQ[gi] <= `FDI_REG_RESET;
        end else if (wrEn && ptrOk && ptrQ[2:0] == 3'(gi) && IMPL_MASK[gi]) begin
          regQ[gi] <= dataQ;
        end
      end
      assign regBank[8*gi +: 8] = regQ[gi];
    end
  endgenerate

  // open-drain drive
  // the level is always low; only the enable moves. The clock line is
  // never driven: no stretching, which also limits how fast the core can
  // keep up at 3.4 Mbps with a 50 MHz sampling clock
  assign sdaOut = 1'b0;
  assign sdaOe_n = ~driveQ;
  assign sclOut = 1'b0;
  assign sclOe_n = 1'b1;

  assign hsMode = hsQ;
  assign shutdown = shutdownQ;

  // checks, one clock domain
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_openDrain;
    sclOe_n && !sdaOut;
  endproperty
  a_openDrain: assert property (p_openDrain) else $error("bus line driven high");

  property p_startToAddr;
    (startDet && !stopDet && hwOkS) |=> (stateQ == S_ADDR) && (bitCntQ == `FDI_BIT_FIRST) && sdaOe_n;
  endproperty
  a_startToAddr: assert property (p_startToAddr) else $error("start not taken");

  property p_stopFrees;
    (stopDet && hwOkS) |=> (stateQ == S_IDLE) && !hsMode && sdaOe_n;
  endproperty
  a_stopFrees: assert property (p_stopFrees) else $error("stop did not free bus");

  property p_ackMatch;
    (sclFall && stateQ == S_ADDR && bitCntQ == `FDI_BIT_ACK && addrMatch && hwOkS)
      |=> !sdaOe_n && (bitCntQ == `FDI_BIT_END);
  endproperty
  a_ackMatch: assert property (p_ackMatch) else $error("matched address not acked");

  property p_noAckForeign;
    (sclFall && stateQ == S_ADDR && bitCntQ == `FDI_BIT_ACK && !addrMatch)
      |=> sdaOe_n && (stateQ == S_SKIP || stateQ == S_IDLE);
  endproperty
  a_noAckForeign: assert property (p_noAckForeign) else $error("foreign address acked");

  property p_masterCode;
    (sclFall && stateQ == S_ADDR && bitCntQ == `FDI_BIT_ACK && hsCode && hwOkS)
      |=> hsMode && sdaOe_n;
  endproperty
  a_masterCode: assert property (p_masterCode) else $error("master code mishandled");

  property p_stableHigh;
    (sclS && !startDet && !stopDet && hwOkS) |=> $stable(sdaOe_n);
  endproperty
  a_stableHigh: assert property (p_stableHigh) else $error("data moved while clock high");

  property p_commitTime;
    (!wrEn && hwOkS) |=> $stable(regBank);
  endproperty
  a_commitTime: assert property (p_commitTime) else $error("register changed early");

  property p_commitValue;
    (wrEn && ptrOk && ptrQ[2:0] == 3'h0 && IMPL_MASK[0] && hwOkS) |=> regBank[7:0] == $past(dataQ);
  endproperty
  a_commitValue: assert property (p_commitValue) else $error("register not written");

  property p_unmapped;
    !ptrOk |-> (readData == `FDI_READ_ZERO);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_hwReset;
    !hwOkS |=> (regBank == '0) && (stateQ == S_IDLE) && shutdown && sdaOe_n;
  endproperty
  a_hwReset: assert property (p_hwReset) else $error("disable did not reset");

endmodule : fdi_flash_i2c_slave

`default_nettype wire

// *** test/fdi_i2c_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// bus master on the far side, drives both lines open drain
module fdi_i2c_master_model (
  // clock that paces the master
  input wire logic clk_sys,
  // wired levels of both lines
  input wire logic sclIn,
  input wire logic sdaIn,
  // pull-down enables, low while the master pulls a line low
  output var logic sclOe_n,
  output var logic sdaOe_n
);
  // half bit time in clock cycles, chosen by the bench per rate
  int hp = 63;

  // both lines released: the pull-ups hold them high
  initial begin
    sclOe_n = 1'b1;
    sdaOe_n = 1'b1;
  end

  // wait whole cycles, acting just after a falling edge
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt

  // start, or repeated start from clock low
  task automatic start();
    wt(2);
    sdaOe_n = 1'b1;
    wt(hp);
    sclOe_n = 1'b1;
    wt(hp);
    sdaOe_n = 1'b0;
    wt(hp);
    sclOe_n = 1'b0;
  endtask : start

  // stop: data rises while clock high
  task automatic stop();
    wt(2);
    sdaOe_n = 1'b0;
    wt(hp);
    sclOe_n = 1'b1;
    wt(hp);
    sdaOe_n = 1'b1;
    wt(hp);
  endtask : stop

  // data moves two cycles after the fall, well inside the low phase
  task automatic half1(input logic b);
    wt(2);
    sdaOe_n = b;
    wt(hp - 2);
    sclOe_n = 1'b1;
    wt(hp);
  endtask : half1

  // sample at the end of the high phase, then pull the clock low
  task automatic half2(output logic r);
    r = sdaIn;
    sclOe_n = 1'b0;
  endtask : half2

  // msb first, ninth bit released for the device answer
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      half1(d[i]);
      half2(r);
    end
    half1(1'b1);
    half2(r);
    ack = !r;
  endtask : wrByte

  // master answers each read byte, nack on the last
  task automatic rdByte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      half1(1'b1);
      half2(d[i]);
    end
    half1(!ackIt);
    half2(r);
  endtask : rdByte
endmodule : fdi_i2c_master_model

`default_nettype wire

// *** test/fdi_flash_i2c_slave_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module fdi_flash_i2c_slave_tb;
  // clock, reset and disable pin
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  // pin held high outside the disable scenario
  logic hwDisableLow = 1'b1;
  // enables of master and device, wired-and with pull-ups
  logic mSclOe_n;
  logic mSdaOe_n;
  logic dSclOe_n;
  logic dSdaOe_n;
  wire logic sclWire = mSclOe_n & dSclOe_n;
  wire logic sdaWire = mSdaOe_n & dSdaOe_n;
  // device status
  logic shutdown;
  logic hsMode;
  logic [63:0] regBank;
  // bench bookkeeping
  int errTotal = 0;
  int compares = 0;
  int cyc = 0;
  logic prevScl = 1'b1;
  logic prevOe = 1'b1;
  logic [7:0] expReg [8];
  logic [6:0] badAddr [4] = '{7'h00, 7'h78, 7'h32, 7'h73};

  always #10 clk_sys = ~clk_sys;

  // reg 7 left unmapped so reads there must give zero
  fdi_flash_i2c_slave #(.IMPL_MASK(8'h7F)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .hwDisableLow(hwDisableLow),
    .sclIn(sclWire), .sclOut(), .sclOe_n(dSclOe_n),
    .sdaIn(sdaWire), .sdaOut(), .sdaOe_n(dSdaOe_n),
    .shutdown(shutdown), .hsMode(hsMode), .regBank(regBank)
  );

  fdi_i2c_master_model mdl (
    .clk_sys(clk_sys), .sclIn(sclWire), .sdaIn(sdaWire),
    .sclOe_n(mSclOe_n), .sdaOe_n(mSdaOe_n)
  );

  // compare one value and count it
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  // counts, verdict and end of run
  task automatic summarize();
    $display("compares=%0d errTotal=%0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // mapped registers 0..6 against the bench copy
  task automatic chkBank();
    for (int i = 0; i < 7; i++)
      check(regBank[8*i+:8], expReg[i]);
  endtask : chkBank

  // write one register, no stop so a repeated start may follow
  task automatic wrSeq(input logic [7:0] ptr, input logic [7:0] val);
    logic a;
    mdl.start();
    mdl.wrByte({7'h33, 1'b0}, a);
    check(a, 1'b1);
    mdl.wrByte(ptr, a);
    check(a, 1'b1);
    mdl.wrByte(val, a);
    check(a, 1'b1);
    if (ptr < 8'h08) expReg[ptr[2:0]] = val;
  endtask : wrSeq

  // pointer write, repeated start, read one or two bytes
  task automatic rdSeq(input logic [7:0] ptr, input logic [7:0] exp, input bit twice);
    logic a;
    logic [7:0] d;
    mdl.start();
    mdl.wrByte({7'h33, 1'b0}, a);
    mdl.wrByte(ptr, a);
    check(a, 1'b1);
    mdl.start();
    mdl.wrByte({7'h33, 1'b1}, a);
    check(a, 1'b1);
    if (twice) begin
      mdl.rdByte(1'b1, d);
      check(d, exp);
    end
    mdl.rdByte(1'b0, d);
    check(d, exp);
  endtask : rdSeq

  // register must change only at the fall that ends the data ack
  task automatic tUpdate();
    logic a;
    logic [7:0] v;
    v = 8'hA5;
    mdl.start();
    mdl.wrByte({7'h33, 1'b0}, a);
    mdl.wrByte(8'h03, a);
    for (int i = 7; i >= 0; i--) begin
      mdl.half1(v[i]);
      mdl.half2(a);
    end
    mdl.half1(1'b1);
    repeat (10) @(negedge clk_sys);
    check(regBank[31:24], 8'h00);
    mdl.half2(a);
    check(a, 1'b0);
    repeat (6) @(negedge clk_sys);
    check(regBank[31:24], 8'hA5);
    expReg[3] = 8'hA5;
    mdl.stop();
    rdSeq(8'h03, 8'hA5, 1'b0);
    mdl.stop();
  endtask : tUpdate

  // foreign addresses, general call and 10-bit prefix stay silent
  task automatic tBadAddr();
    logic a;
    foreach (badAddr[k]) begin
      mdl.start();
      mdl.wrByte({badAddr[k], 1'b0}, a);
      check(a, 1'b0);
      mdl.wrByte(8'h03, a);
      check(a, 1'b0);
      mdl.stop();
    end
    chkBank();
  endtask : tBadAddr

  // bad upper pointer bits and unmapped register
  task automatic tPointer();
    wrSeq(8'h0B, 8'h5A);
    mdl.stop();
    chkBank();
    rdSeq(8'h08, 8'h00, 1'b0);
    mdl.stop();
    wrSeq(8'h07, 8'hFF);
    mdl.stop();
    rdSeq(8'h07, 8'h00, 1'b0);
    mdl.stop();
  endtask : tPointer

  // every master code unacked, then fast traffic on repeated starts
  task automatic tHs();
    logic a;
    for (int c = 0; c < 8; c++) begin
      mdl.start();
      mdl.wrByte({5'h01, 3'(c)}, a);
      check(a, 1'b0);
    end
    repeat (4) @(negedge clk_sys);
    check(hsMode, 1'b1);
    mdl.hp = 8;
    // no stop between transfers keeps the fast rate
    for (int i = 0; i < 7; i++) begin
      wrSeq(8'(i), 8'h21 + 8'(i) * 8'h13);
      rdSeq(8'(i), expReg[i], i == 3);
    end
    chkBank();
    mdl.stop();
    repeat (4) @(negedge clk_sys);
    check(hsMode, 1'b0);
    mdl.hp = 63;
  endtask : tHs

  // disable pin in mid-sequence clears everything
  task automatic tDisable();
    logic a;
    mdl.start();
    mdl.wrByte(8'h08, a);
    hwDisableLow = 1'b0;
    repeat (5) @(negedge clk_sys);
    check(shutdown, 1'b1);
    check(hsMode, 1'b0);
    check(regBank, 64'h0);
    hwDisableLow = 1'b1;
    repeat (5) @(negedge clk_sys);
    check(shutdown, 1'b0);
    mdl.stop();
    foreach (expReg[i]) expReg[i] = 8'h00;
    wrSeq(8'h01, 8'h3C);
    mdl.stop();
    chkBank();
  endtask : tDisable

  // device data must not move while the clock is high
  always @(posedge clk_sys) begin
    if (rst_n && sclWire && prevScl && dSdaOe_n !== prevOe)
      check(dSdaOe_n, prevOe);
    prevScl <= sclWire;
    prevOe <= dSdaOe_n;
  end

  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      errTotal++;
      summarize();
    end
  end

  // main sequence
  initial begin
    foreach (expReg[i]) expReg[i] = 8'h00;
    repeat (16) @(negedge clk_sys);
    check(shutdown, 1'b1);
    check(regBank, 64'h0);
    check(dSdaOe_n, 1'b1);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    check(shutdown, 1'b0);
    check(hsMode, 1'b0);
    tUpdate();
    tBadAddr();
    tPointer();
    tHs();
    tDisable();
    check(dSclOe_n, 1'b1);
    summarize();
  end
endmodule : fdi_flash_i2c_slave_tb

`default_nettype wire
